/* File: rtl/mhr_regs.sv */
/*
  Host register bank of a 1553 BC/RT/monitor core: masks and sticky status,
  configuration, command pulses, time tag, BC timers, pointers, flags.
  Assumes protocol engines on the same clock drive the event and update ports.
*/
// How it works
// R1 - Events latch only when their enable bit set
// R2 - Host sets level interrupt bit before use
// R3 - Command writes fire one-shot action pulses
// R4 - Separate stop-after-message and stop-after-frame requests
// R5 - Readable pointer of current or last message
// R6 - Control word mirror follows BC or RT
// R7 - Free time tag, 2 to 64 us ticks
// R8 - Time tag stamped at message start/end
// R9 - Status bits align with their mask bits
// R10 - Chain flag shows pending first-status event
// R11 - Data stack address readable, writable, tracked
// R12 - Frame remaining counts down in 100us
// R13 - Message gap counts down in 1us
// R14 - BC frame period writable in 100us
// R15 - RT mode shows last command word
// R16 - Monitor trigger word match starts/stops/interrupts; in pulse mode it only latches the status bit and raises no irq_req
// R17 - Initial list pointer written, current read
// R18 - Reset clears configuration except enhanced CPU access
// R19 - Condition flags readable, not writable
// R20 - Host sets, clears, toggles GP flags
// R21 - GP queue pointer loaded, read, advanced
// R22 - Status queue pointer loaded, read, advanced outside BC mode
// R23 - List pointer loads initial, then advances
// R24 - Writes to read-only registers are ignored
`include "mhr_map.svh"
`timescale 1ns/10ps
`default_nettype none
module mhr_regs
  import mhr_pkg::*;
#(
  parameter int FRAME_LSB_CYCLES = `MHR_FRAME_LSB_US * `MHR_US_NS / `MHR_CLK_PERIOD_NS
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  addr,
  input  wire logic [15:0] wr_data,
  input  wire logic        wr_stb,
  input  wire logic        rd_stb,
  output logic [15:0]      rd_data,
  input  wire logic [15:0] evt1,
  input  wire logic [15:0] evt2,
  input  wire logic        msg_start,
  input  wire logic        msg_end,
  input  wire logic [15:0] stack_ptr_in,
  input  wire logic [15:0] bc_ctrl_word,
  input  wire logic [15:0] rt_sa_ctrl_word,
  input  wire logic        dstack_wr,
  input  wire logic [15:0] dstack_addr_in,
  input  wire logic        rt_cmd_valid,
  input  wire logic [15:0] rt_cmd_word,
  input  wire logic        mon_word_valid,
  input  wire logic [15:0] mon_word,
  input  wire logic        frame_start,
  input  wire logic        gap_load,
  input  wire logic [15:0] gap_value,
  input  wire logic        ilp_advance,
  input  wire logic        gpq_advance,
  input  wire logic        isq_advance,
  input  wire logic [7:0]  cond_flags,
  input  wire logic [15:0] rt_status_in,
  input  wire logic [15:0] bit_word_in,
  input  wire logic [15:0] bit_test_in,
  output logic             irq_req,
  output logic [`MHR_CMD_W-1:0] cmd_pulse,
  output logic             message_start_stamp,
  output logic             message_end_stamp,
  output logic [15:0]      stamp_value,
  output logic             trig_start,
  output logic             trig_stop,
  output logic [7:0]       gp_flags,
  output logic [15:0]      ilp,
  output logic [15:0]      frame_remain,
  output logic [15:0]      msg_remain,
  output logic [15:0]      cfg1_out,
  output logic [15:0]      cfg2_out
);
  localparam int US_CYCLES = `MHR_US_NS / `MHR_CLK_PERIOD_NS;
  localparam int FRAME_US = FRAME_LSB_CYCLES / US_CYCLES;
  logic [15:0] imask1_reg;
  logic [15:0] imask2_reg;
  logic [15:0] istat1_reg;
  logic [15:0] istat2_reg;
  logic [15:0] cfg_reg [1:7];
  logic [15:0] time_tag_reg;
  logic [15:0] dstack_reg;
  logic [15:0] frame_time_reg;
  logic [15:0] last_cmd_reg;
  logic [15:0] trig_word_reg;
  logic [15:0] init_ilp_reg;
  logic [15:0] gpq_reg;
  logic [15:0] isq_reg;
  logic [15:0] rd_next;
  logic        us_tick;
  logic        frame_tick;
  logic        tt_tick;
  logic [6:0]  tt_period;
  logic        wr_cmd;
  logic        soft_rst;
  logic        trig_hit;
  mhr_mode_t   mode;
  assign mode     = mhr_mode_t'(cfg_reg[1][`MHR_CFG1_MODE_LO +: 2]);
  assign wr_cmd   = wr_stb && (addr == `MHR_OFF_CMD);
  assign soft_rst = wr_cmd && wr_data[`MHR_CMD_SOFT_RST];
  assign trig_hit = mon_word_valid && (mode == MHR_MT) && (mon_word == trig_word_reg);
  assign cfg1_out = cfg_reg[1];
  assign cfg2_out = cfg_reg[2];
  // Codes above 5 saturate at the slowest rate
  assign tt_period = (cfg_reg[2][`MHR_CFG2_TT_LO +: 3] > 3'h5) ? 7'h40
                   : 7'h02 << cfg_reg[2][`MHR_CFG2_TT_LO +: 3]; // R7
  mhr_tick u_us_tick (
    .clk    (clk),
    .rst    (rst),
    .clr    (1'b0),
    .en     (1'b1),
    .period (7'(US_CYCLES)),
    .tick   (us_tick)
  );
  mhr_tick u_frame_tick (
    .clk    (clk),
    .rst    (rst),
    .clr    (frame_start),
    .en     (us_tick),
    .period (7'(FRAME_US)),
    .tick   (frame_tick)
  );
  // Prescaler restarts on the time tag reset command, not on soft reset, so the first count after it is a full period
  mhr_tick u_tt_tick (
    .clk    (clk),
    .rst    (rst),
    .clr    (wr_cmd && wr_data[`MHR_CMD_TT_RST]),
    .en     (us_tick),
    .period (tt_period),
    .tick   (tt_tick)
  );
  // Configuration; writes in the same cycle as soft reset are dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_reg    <= '{default: `MHR_RST_CFG}; // R18
      cfg_reg[6] <= `MHR_RST_CFG6; // R18
      imask1_reg <= 16'h0000;
      imask2_reg <= 16'h0000;
    end else if (soft_rst) begin
      cfg_reg    <= '{default: `MHR_RST_CFG}; // R18
      cfg_reg[6] <= `MHR_RST_CFG6; // R18
      imask1_reg <= 16'h0000;
      imask2_reg <= 16'h0000;
    end else if (wr_stb) begin
      case (addr)
        `MHR_OFF_IMASK1: imask1_reg <= wr_data;
        `MHR_OFF_IMASK2: imask2_reg <= wr_data;
        `MHR_OFF_CFG1:   cfg_reg[1] <= wr_data;
        `MHR_OFF_CFG2:   cfg_reg[2] <= wr_data;
        `MHR_OFF_CFG3:   cfg_reg[3] <= wr_data;
        `MHR_OFF_CFG4:   cfg_reg[4] <= wr_data;
        `MHR_OFF_CFG5:   cfg_reg[5] <= wr_data;
        `MHR_OFF_CFG6:   cfg_reg[6] <= wr_data;
        `MHR_OFF_CFG7:   cfg_reg[7] <= wr_data;
        default:         ; // R24
      endcase
    end
  end
  // Sticky status; a new event beats the interrupt-reset clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      istat1_reg <= 16'h0000;
      istat2_reg <= 16'h0000;
    end else begin
      if (wr_cmd && (wr_data[`MHR_CMD_INT_RST] || wr_data[`MHR_CMD_SOFT_RST])) begin
        istat1_reg <= evt1 & imask1_reg; // R1 R9
        istat2_reg <= evt2 & imask2_reg; // R1 R9
      end else begin
        istat1_reg <= istat1_reg | (evt1 & imask1_reg); // R1 R9
        istat2_reg <= istat2_reg | (evt2 & imask2_reg); // R1 R9
      end
      if (trig_hit && imask2_reg[`MHR_ISTAT2_TRIG]) begin
        istat2_reg[`MHR_ISTAT2_TRIG] <= 1'b1; // R16
      end
      istat2_reg[`MHR_ISTAT2_CHAIN] <= 1'b0;
    end
  end
  // Level follows pending status; pulse mode follows enabled evt1/evt2 inputs one cycle later, not trigger matches
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq_req <= 1'b0;
    end else if (cfg_reg[2][`MHR_CFG2_LEVEL]) begin
      irq_req <= (|istat1_reg) || (|istat2_reg); // R2
    end else begin
      irq_req <= (|(evt1 & imask1_reg)) || (|(evt2 & imask2_reg));
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_pulse <= '0;
    end else begin
      cmd_pulse <= wr_cmd ? wr_data[`MHR_CMD_W-1:0] : '0; // R3 R4
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      time_tag_reg <= 16'h0000;
    end else if (wr_cmd && (wr_data[`MHR_CMD_TT_RST] || wr_data[`MHR_CMD_SOFT_RST])) begin
      time_tag_reg <= 16'h0000;
    end else if (tt_tick || (wr_cmd && wr_data[`MHR_CMD_TT_TEST])) begin
      time_tag_reg <= time_tag_reg + 16'h0001; // R7
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      message_start_stamp <= 1'b0;
      message_end_stamp   <= 1'b0;
      stamp_value         <= 16'h0000;
    end else begin
      message_start_stamp <= msg_start; // R8
      message_end_stamp   <= msg_end; // R8
      if (msg_start || msg_end) begin
        stamp_value <= time_tag_reg; // R8
      end
    end
  end
  // Engine update wins over a host write in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dstack_reg <= 16'h0000;
    end else if (dstack_wr) begin
      dstack_reg <= dstack_addr_in; // R11
    end else if (wr_stb && addr == `MHR_OFF_DSTACK) begin
      dstack_reg <= wr_data; // R11
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_time_reg <= 16'h0000;
      trig_word_reg  <= 16'h0000;
    end else if (wr_stb && addr == `MHR_OFF_FRAME_CMD) begin
      if (mode == MHR_BC) begin
        frame_time_reg <= wr_data; // R14
      end else if (mode == MHR_MT) begin
        trig_word_reg <= wr_data; // R16
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      last_cmd_reg <= 16'h0000;
    end else if (rt_cmd_valid) begin
      last_cmd_reg <= rt_cmd_word; // R15
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      trig_start <= 1'b0;
      trig_stop  <= 1'b0;
    end else begin
      trig_start <= trig_hit && cfg_reg[1][`MHR_CFG1_TRIG_GO]; // R16
      trig_stop  <= trig_hit && cfg_reg[1][`MHR_CFG1_TRIG_END]; // R16
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frame_remain <= 16'h0000;
    end else if (frame_start) begin
      frame_remain <= frame_time_reg; // R12
    end else if (frame_tick && frame_remain != 16'h0000) begin
      frame_remain <= frame_remain - 16'h0001; // R12
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      msg_remain <= 16'h0000;
    end else if (gap_load) begin
      msg_remain <= gap_value; // R13
    end else if (us_tick && msg_remain != 16'h0000) begin
      msg_remain <= msg_remain - 16'h0001; // R13
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      init_ilp_reg <= 16'h0000;
      ilp          <= 16'h0000;
    end else if (wr_stb && addr == `MHR_OFF_INIT_ILP) begin
      init_ilp_reg <= wr_data; // R17
      ilp          <= wr_data; // R23
    end else if (ilp_advance) begin
      ilp <= ilp + 16'h0002; // R23
    end
  end
  // Both halves set on one bit toggles it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gp_flags <= 8'h00;
    end else if (wr_stb && addr == `MHR_OFF_GP_FLAG) begin
      for (int i = 0; i < 8; i++) begin
        case ({wr_data[i+8], wr_data[i]})
          2'b01:   gp_flags[i] <= 1'b1; // R20
          2'b10:   gp_flags[i] <= 1'b0; // R20
          2'b11:   gp_flags[i] <= ~gp_flags[i]; // R20
          default: gp_flags[i] <= gp_flags[i];
        endcase
      end
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gpq_reg <= 16'h0000;
    end else if (wr_stb && addr == `MHR_OFF_GPQ_PTR) begin
      gpq_reg <= wr_data; // R21
    end else if (gpq_advance) begin
      gpq_reg <= gpq_reg + 16'h0001; // R21
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      isq_reg <= 16'h0000;
    end else if (wr_stb && addr == `MHR_OFF_ISQ_PTR) begin
      isq_reg <= wr_data; // R22
    end else if (isq_advance && mode != MHR_BC) begin
      isq_reg <= isq_reg + 16'h0001; // R22
    end
  end
  always_comb begin
    case (addr)
      `MHR_OFF_IMASK1:    rd_next = imask1_reg;
      `MHR_OFF_IMASK2:    rd_next = imask2_reg;
      `MHR_OFF_CFG1:      rd_next = cfg_reg[1];
      `MHR_OFF_CFG2:      rd_next = cfg_reg[2];
      `MHR_OFF_CFG3:      rd_next = cfg_reg[3];
      `MHR_OFF_CFG4:      rd_next = cfg_reg[4];
      `MHR_OFF_CFG5:      rd_next = cfg_reg[5];
      `MHR_OFF_CFG6:      rd_next = cfg_reg[6];
      `MHR_OFF_CFG7:      rd_next = cfg_reg[7];
      `MHR_OFF_STACK_PTR: rd_next = stack_ptr_in; // R5
      `MHR_OFF_ILP:       rd_next = ilp; // R17
      `MHR_OFF_CTRL_WORD: rd_next = (mode == MHR_BC) ? bc_ctrl_word : rt_sa_ctrl_word; // R6
      `MHR_OFF_TIME_TAG:  rd_next = time_tag_reg;
      `MHR_OFF_ISTAT1:    rd_next = istat1_reg; // R9
      `MHR_OFF_ISTAT2:    rd_next = {istat2_reg[15:1], |istat1_reg}; // R10
      `MHR_OFF_DSTACK:    rd_next = dstack_reg;
      `MHR_OFF_FRAME_REM: rd_next = frame_remain;
      `MHR_OFF_MSG_REM:   rd_next = msg_remain;
      `MHR_OFF_FRAME_CMD: rd_next = (mode == MHR_BC) ? frame_time_reg :
                                    (mode == MHR_MT) ? trig_word_reg : last_cmd_reg; // R15
      `MHR_OFF_INIT_ILP:  rd_next = init_ilp_reg;
      `MHR_OFF_RT_STATUS: rd_next = rt_status_in;
      `MHR_OFF_BIT_WORD:  rd_next = bit_word_in;
      `MHR_OFF_COND:      rd_next = {cond_flags, gp_flags}; // R19
      `MHR_OFF_BIT_TEST:  rd_next = bit_test_in;
      `MHR_OFF_GPQ_PTR:   rd_next = gpq_reg;
      `MHR_OFF_ISQ_PTR:   rd_next = isq_reg;
      default:            rd_next = 16'h0000;
    endcase
  end
  // Data only in the cycle after the read strobe
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= 16'h0000;
    end else begin
      rd_data <= rd_stb ? rd_next : 16'h0000;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/mhr_map.svh */
/*
  Register offsets, field positions, reset values and timing counts of the
  host register bank. Definitions only; included by mhr_regs, the checker and the bench.
*/
`ifndef MHR_MAP_SVH
`define MHR_MAP_SVH

`define MHR_ADDR_W        5
`define MHR_DATA_W        16

`define MHR_OFF_IMASK1    5'h00
`define MHR_OFF_CFG1      5'h01
`define MHR_OFF_CFG2      5'h02
`define MHR_OFF_CMD       5'h03
`define MHR_OFF_STACK_PTR 5'h04
`define MHR_OFF_ILP       5'h05
`define MHR_OFF_CTRL_WORD 5'h06
`define MHR_OFF_TIME_TAG  5'h07
`define MHR_OFF_ISTAT1    5'h08
`define MHR_OFF_CFG3      5'h09
`define MHR_OFF_CFG4      5'h0A
`define MHR_OFF_CFG5      5'h0B
`define MHR_OFF_DSTACK    5'h0C
`define MHR_OFF_FRAME_REM 5'h0D
`define MHR_OFF_MSG_REM   5'h0E
`define MHR_OFF_FRAME_CMD 5'h0F
`define MHR_OFF_INIT_ILP  5'h10
`define MHR_OFF_RT_STATUS 5'h11
`define MHR_OFF_BIT_WORD  5'h12
`define MHR_OFF_CFG6      5'h13
`define MHR_OFF_CFG7      5'h14
`define MHR_OFF_COND      5'h15
`define MHR_OFF_GP_FLAG   5'h16
`define MHR_OFF_BIT_TEST  5'h17
`define MHR_OFF_GPQ_PTR   5'h18
`define MHR_OFF_ISQ_PTR   5'h19
`define MHR_OFF_IMASK2    5'h1A
`define MHR_OFF_ISTAT2    5'h1B

// Command register bits
`define MHR_CMD_SOFT_RST  0
`define MHR_CMD_START     1
`define MHR_CMD_INT_RST   2
`define MHR_CMD_TT_RST    3
`define MHR_CMD_TT_TEST   4
`define MHR_CMD_STOP_FRM  5
`define MHR_CMD_STOP_MSG  6
`define MHR_CMD_PROT_BIT  7
`define MHR_CMD_RAM_BIT   8
`define MHR_CMD_CLR_BIT   9
`define MHR_CMD_CLR_HALT  10
`define MHR_CMD_W         11

// Field positions
`define MHR_CFG1_MODE_LO  14
`define MHR_CFG1_TRIG_GO  1
`define MHR_CFG1_TRIG_END 0
`define MHR_CFG2_LEVEL    3
`define MHR_CFG2_TT_LO    7
`define MHR_CFG6_ENH_CPU  14
`define MHR_ISTAT2_CHAIN  0
`define MHR_ISTAT2_TRIG   15

// Reset values
`define MHR_RST_CFG       16'h0000
`define MHR_RST_CFG6      16'h4000

// Timing
`define MHR_CLK_PERIOD_NS 20
`define MHR_US_NS         1000
`define MHR_FRAME_LSB_US  100

`endif

/* File: rtl/mhr_pkg.sv */
/*
  Types shared by the host register bank. Assumes mhr_map.svh alongside.
*/
package mhr_pkg;
  typedef enum logic [1:0] {
    MHR_BC,
    MHR_RT,
    MHR_MT,
    MHR_RTMT
  } mhr_mode_t;
endpackage

/* File: rtl/mhr_tick.sv */
/*
  Enable-pulse divider: one tick per 'period' qualifying enables.
  Assumes a single clock and period of at least one.
*/
`timescale 1ns/10ps
`default_nettype none
module mhr_tick (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic [6:0] period,
  output logic            tick
);
  logic [6:0] cnt_reg;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 7'h00;
      tick    <= 1'b0;
    end else if (clr) begin
      cnt_reg <= 7'h00;
      tick    <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (en) begin
        if (cnt_reg >= period - 7'h01) begin
          cnt_reg <= 7'h00;
          tick    <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 7'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/mhr_regs_asserts.sv */
/*
  Port checker of the host register bank.
  Assumes one clock and an active high reset; bound to mhr_regs below.
*/
`include "mhr_map.svh"
`timescale 1ns/10ps
`default_nettype none
module mhr_regs_asserts (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [4:0]  addr,
  input wire logic [15:0] wr_data,
  input wire logic        wr_stb,
  input wire logic [15:0] evt1,
  input wire logic [15:0] evt2,
  input wire logic        msg_start,
  input wire logic        msg_end,
  input wire logic        mon_word_valid,
  input wire logic        gap_load,
  input wire logic [15:0] gap_value,
  input wire logic        ilp_advance,
  input wire logic        irq_req,
  input wire logic [10:0] cmd_pulse,
  input wire logic        message_start_stamp,
  input wire logic        message_end_stamp,
  input wire logic [15:0] stamp_value,
  input wire logic        trig_start,
  input wire logic [15:0] ilp,
  input wire logic [15:0] msg_remain,
  input wire logic [15:0] cfg1_out,
  input wire logic [15:0] cfg2_out
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire logic w_cmd = wr_stb && addr == `MHR_OFF_CMD;
  wire logic w_ilp = wr_stb && addr == `MHR_OFF_INIT_ILP;
  a_cmd_copy: assert property (w_cmd |=> cmd_pulse == $past(wr_data[10:0]))
    else $error("cmd_pulse differs from command write");
  a_cmd_quiet: assert property (!w_cmd |=> cmd_pulse == 11'h000)
    else $error("cmd_pulse without command write");
  a_irq_cause: assert property (irq_req && !$past(cfg2_out[3]) |-> $past(|evt1 || |evt2 || mon_word_valid))
    else $error("pulse request without event");
  a_start_stamp: assert property (message_start_stamp == $past(msg_start))
    else $error("start stamp pulse misplaced");
  a_end_stamp: assert property (message_end_stamp == $past(msg_end))
    else $error("end stamp pulse misplaced");
  a_stamp_hold: assert property (!$past(msg_start || msg_end) |-> $stable(stamp_value))
    else $error("stamp value moved without message");
  a_gap_load: assert property (gap_load |=> msg_remain == $past(gap_value))
    else $error("message timer not loaded");
  a_gap_step: assert property (!gap_load && msg_remain != 16'h0000 |=>
    msg_remain == $past(msg_remain) || msg_remain == $past(msg_remain) - 16'h0001)
    else $error("message timer jumped");
  a_ilp_load: assert property (w_ilp && !ilp_advance |=> ilp == $past(wr_data))
    else $error("list pointer not loaded");
  a_ilp_step: assert property (ilp_advance && !w_ilp |=> ilp == $past(ilp) + 16'h0002)
    else $error("list pointer step wrong");
  a_trig_gate: assert property (trig_start |-> $past(mon_word_valid && cfg1_out[1] && cfg1_out[15]))
    else $error("trigger start without match in monitor mode");
  c_irq: cover property (irq_req);
  c_trig: cover property (trig_start);
  c_ilp: cover property (ilp_advance);
endmodule
bind mhr_regs mhr_regs_asserts i_chk (.clk, .rst, .addr, .wr_data, .wr_stb, .evt1, .evt2, .msg_start,
  .msg_end, .mon_word_valid, .gap_load, .gap_value, .ilp_advance, .irq_req, .cmd_pulse,
  .message_start_stamp, .message_end_stamp, .stamp_value, .trig_start, .ilp, .msg_remain,
  .cfg1_out, .cfg2_out);
`default_nettype wire

/* File: tb/mhr_regs_tb_top.sv */
/*
  Self-checking bench of the host register bank.
  Assumes mhr_map.svh on the include path; shortened frame tick.
*/
`include "mhr_map.svh"
`timescale 1ns/10ps
`default_nettype none
module mhr_regs_tb_top;
  localparam int LSB = 100;
  localparam int US  = 50;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [4:0]  addr = 5'h00;
  logic [15:0] wr_data = 16'h0000;
  logic        wr_stb = 1'b0;
  logic        rd_stb = 1'b0;
  logic [9:0]  pl = 10'h000;
  logic [15:0] evt1 = 16'h0000, evt2 = 16'h0000, stack_ptr_in = 16'h0000, bc_ctrl_word = 16'h0000;
  logic [15:0] rt_sa_ctrl_word = 16'h0000, dstack_addr_in = 16'h0000, rt_cmd_word = 16'h0000;
  logic [15:0] mon_word = 16'h0000, gap_value = 16'h0000, rt_status_in = 16'h0000;
  logic [15:0] bit_word_in = 16'h0000, bit_test_in = 16'h0000;
  logic [7:0]  cond_flags = 8'h00;
  logic [15:0] rd_data, stamp_value, ilp, frame_remain, msg_remain, cfg1_out, cfg2_out;
  logic [10:0] cmd_pulse;
  logic [7:0]  gp_flags;
  logic        irq_req, message_start_stamp, message_end_stamp, trig_start, trig_stop;
  int          err_total = 0;
  int          n_tests = 0;
  always #10 clk = ~clk;
  mhr_regs #(.FRAME_LSB_CYCLES(LSB)) i_dut (
    .clk, .rst, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data, .evt1, .evt2,
    .msg_start(pl[4]), .msg_end(pl[5]), .stack_ptr_in, .bc_ctrl_word, .rt_sa_ctrl_word,
    .dstack_wr(pl[3]), .dstack_addr_in, .rt_cmd_valid(pl[8]), .rt_cmd_word,
    .mon_word_valid(pl[9]), .mon_word, .frame_start(pl[6]), .gap_load(pl[7]), .gap_value,
    .ilp_advance(pl[0]), .gpq_advance(pl[1]), .isq_advance(pl[2]), .cond_flags,
    .rt_status_in, .bit_word_in, .bit_test_in, .irq_req, .cmd_pulse,
    .message_start_stamp, .message_end_stamp, .stamp_value, .trig_start, .trig_stop,
    .gp_flags, .ilp, .frame_remain, .msg_remain, .cfg1_out, .cfg2_out);
  task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
    n_tests++;
    if (got !== ex) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, input logic [15:0] ex, input string nm);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 chk(nm, ex, rd_data);
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    pl[i] <= 1'b1;
    @(posedge clk);
    pl <= 10'h000;
  endtask
  task automatic t_reset;
    rd(`MHR_OFF_CFG1, 16'h0000, "cfg1");
    rd(`MHR_OFF_CFG6, 16'h4000, "cfg6");
    rd(`MHR_OFF_CFG7, 16'h0000, "cfg7");
    chk("cfg2_out", 16'h0000, cfg2_out);
    $display("t_reset done");
  endtask
  task automatic t_irq;
    wr(`MHR_OFF_CFG2, 16'h0008);
    wr(`MHR_OFF_IMASK1, 16'h0008);
    wr(`MHR_OFF_IMASK2, 16'h0010);
    @(posedge clk);
    evt1 <= 16'h000C;
    evt2 <= 16'h0030;
    @(posedge clk);
    evt1 <= 16'h0000;
    evt2 <= 16'h0000;
    rd(`MHR_OFF_ISTAT1, 16'h0008, "istat1");
    rd(`MHR_OFF_ISTAT2, 16'h0011, "istat2");
    chk("irq level", 16'h0001, {15'h0000, irq_req});
    wr(`MHR_OFF_CMD, 16'h0004);
    rd(`MHR_OFF_ISTAT1, 16'h0000, "istat1 clr");
    chk("irq clr", 16'h0000, {15'h0000, irq_req});
    $display("t_irq done");
  endtask
  task automatic t_cmd;
    for (int i = 1; i < 11; i++) begin
      wr(`MHR_OFF_CMD, 16'h0001 << i);
      #1 chk("cmd_pulse", 16'h0001 << i, {5'h00, cmd_pulse});
    end
    rd(`MHR_OFF_CMD, 16'h0000, "cmd read");
    wr(`MHR_OFF_CFG1, 16'h4000);
    wr(`MHR_OFF_CMD, 16'h0001);
    #1 chk("soft rst", 16'h0001, {5'h00, cmd_pulse});
    rd(`MHR_OFF_CFG1, 16'h0000, "cfg1 soft");
    rd(`MHR_OFF_CFG6, 16'h4000, "cfg6 soft");
    $display("t_cmd done");
  endtask
  task automatic t_ro;
    {stack_ptr_in, bc_ctrl_word, rt_sa_ctrl_word} <= {16'h1234, 16'hB0C1, 16'h5A11};
    {rt_status_in, bit_word_in, bit_test_in, cond_flags} <= {16'h0800, 16'h00F1, 16'h0300, 8'hA5};
    wr(`MHR_OFF_STACK_PTR, 16'hFFFF);
    rd(`MHR_OFF_STACK_PTR, 16'h1234, "stack ptr");
    rd(`MHR_OFF_CTRL_WORD, 16'hB0C1, "bc ctrl");
    wr(`MHR_OFF_COND, 16'hFFFF);
    rd(`MHR_OFF_COND, 16'hA500, "cond");
    wr(`MHR_OFF_RT_STATUS, 16'hFFFF);
    rd(`MHR_OFF_RT_STATUS, 16'h0800, "rt status");
    rd(`MHR_OFF_BIT_WORD, 16'h00F1, "bit word");
    rd(`MHR_OFF_BIT_TEST, 16'h0300, "bit test");
    rd(5'h1F, 16'h0000, "unmapped");
    wr(`MHR_OFF_CFG1, 16'h4000);
    rd(`MHR_OFF_CTRL_WORD, 16'h5A11, "rt ctrl");
    $display("t_ro done");
  endtask
  task automatic t_ptr;
    wr(`MHR_OFF_INIT_ILP, 16'h0100);
    pulse(0);
    rd(`MHR_OFF_ILP, 16'h0102, "ilp");
    chk("ilp port", 16'h0102, ilp);
    wr(`MHR_OFF_GPQ_PTR, 16'h0020);
    pulse(1);
    rd(`MHR_OFF_GPQ_PTR, 16'h0021, "gpq");
    wr(`MHR_OFF_ISQ_PTR, 16'h0040);
    pulse(2);
    rd(`MHR_OFF_ISQ_PTR, 16'h0041, "isq");
    wr(`MHR_OFF_DSTACK, 16'h0555);
    rd(`MHR_OFF_DSTACK, 16'h0555, "dstack wr");
    dstack_addr_in <= 16'h0777;
    pulse(3);
    rd(`MHR_OFF_DSTACK, 16'h0777, "dstack trk");
    $display("t_ptr done");
  endtask
  task automatic t_gp;
    wr(`MHR_OFF_GP_FLAG, 16'h000F);
    #1 chk("gp set", 16'h000F, {8'h00, gp_flags});
    wr(`MHR_OFF_GP_FLAG, 16'h0303);
    #1 chk("gp toggle", 16'h000C, {8'h00, gp_flags});
    wr(`MHR_OFF_GP_FLAG, 16'h0400);
    #1 chk("gp clear", 16'h0008, {8'h00, gp_flags});
    rd(`MHR_OFF_COND, 16'hA508, "cond gp");
    $display("t_gp done");
  endtask
  task automatic t_frame;
    rt_cmd_word <= 16'h2C45;
    pulse(8);
    wr(`MHR_OFF_FRAME_CMD, 16'h1111);
    rd(`MHR_OFF_FRAME_CMD, 16'h2C45, "rt cmd");
    wr(`MHR_OFF_CFG1, 16'h0000);
    wr(`MHR_OFF_FRAME_CMD, 16'h0002);
    rd(`MHR_OFF_FRAME_CMD, 16'h0002, "frame time");
    pulse(6);
    rd(`MHR_OFF_FRAME_REM, 16'h0002, "frame rem");
    repeat (LSB + 20) @(posedge clk);
    wr(`MHR_OFF_FRAME_REM, 16'hFFFF);
    rd(`MHR_OFF_FRAME_REM, 16'h0001, "frame tick");
    chk("frame port", 16'h0001, frame_remain);
    gap_value <= 16'h0003;
    pulse(7);
    rd(`MHR_OFF_MSG_REM, 16'h0003, "msg rem");
    repeat (US + 10) @(posedge clk);
    rd(`MHR_OFF_MSG_REM, 16'h0002, "msg tick");
    chk("msg port", 16'h0002, msg_remain);
    $display("t_frame done");
  endtask
  task automatic t_tt;
    int per;
    for (int k = 0; k < 6; k++) begin
      per = (2 << k) * US;
      wr(`MHR_OFF_CFG2, 16'h0008 | (16'(k) << 7));
      wr(`MHR_OFF_CMD, 16'h0008);
      repeat (per * 5 / 2) @(posedge clk);
      rd(`MHR_OFF_TIME_TAG, 16'h0002, "time tag");
    end
    wr(`MHR_OFF_CMD, 16'h0010);
    rd(`MHR_OFF_TIME_TAG, 16'h0003, "tt test");
    pulse(4);
    #1 chk("start stamp", 16'h0001, {15'h0000, message_start_stamp});
    chk("stamp", 16'h0003, stamp_value);
    pulse(5);
    #1 chk("end stamp", 16'h0001, {15'h0000, message_end_stamp});
    $display("t_tt done");
  endtask
  task automatic t_trig;
    wr(`MHR_OFF_CFG1, 16'h8002);
    wr(`MHR_OFF_IMASK2, 16'h8000);
    wr(`MHR_OFF_FRAME_CMD, 16'hABCD);
    mon_word <= 16'hABCD;
    pulse(9);
    #1 chk("trig start", 16'h0001, {15'h0000, trig_start});
    chk("trig stop", 16'h0000, {15'h0000, trig_stop});
    chk("cfg1_out", 16'h8002, cfg1_out);
    rd(`MHR_OFF_ISTAT2, 16'h8000, "trig irq");
    // Pulse mode: one request cycle per enabled event
    wr(`MHR_OFF_CFG2, 16'h0000);
    @(posedge clk);
    evt2 <= 16'h8000;
    @(posedge clk);
    evt2 <= 16'h0000;
    #1 chk("irq pulse", 16'h0001, {15'h0000, irq_req});
    @(posedge clk);
    #1 chk("irq pulse end", 16'h0000, {15'h0000, irq_req});
    $display("t_trig done");
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Whole run is about 16k cycles; this only cuts a hang
  initial begin
    #2ms;
    err_total++;
    $display("FAIL watchdog expected end seen hang");
    finish_test();
  end
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_irq();
    t_cmd();
    t_ro();
    t_ptr();
    t_gp();
    t_frame();
    t_tt();
    t_trig();
    finish_test();
  end
endmodule
`default_nettype wire
